// ===== rtl/switch_cfg_regs.sv
`timescale 1ns/10ps
`default_nettype none

module switch_cfg_regs #(
	parameter int EXTEND_CYCLES = switch_cfg_pkg::EXTEND_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        csN,
	input  wire logic        sclk,
	input  wire logic        mosi,
	output logic             miso,
	output logic             misoOe,
	input  wire logic [21:0] switchPins,
	input  wire logic        faultEvent,
	input  wire logic        wakeRequest,
	input  wire logic        pollStart,
	input  wire logic [21:0] diffChange,
	input  wire logic [21:0] finalLevel,
	output logic             sleepMode,
	output logic [21:0]      sleepPollHold,
	output logic [5:0]       analogChannelSel,
	output logic             analogSourceCurrentSel
);

	localparam int CW = $clog2(EXTEND_CYCLES + 1);

	spi_frame_if link ();

	switch_cfg_pkg::power_state_t state_reg;
	switch_cfg_pkg::power_state_t state_next;

	logic [21:0] swMeta_reg;
	logic [21:0] swSync_reg;
	logic [21:0] swPrev_reg;
	logic [21:0] lastStatus_reg;
	logic [7:0]  debProg_reg;
	logic [13:0] debGround_reg;
	logic [5:0]  analogSel_reg;
	logic        analogCur_reg;
	logic [6:0]  prevAddr_reg;
	logic        faultFlag_reg;
	logic        changeFlag_reg;
	logic        wakeReport_reg;
	logic [31:0] txWord_reg;
	logic [31:0] txWord_next;
	logic [CW-1:0] extendCount_reg;
	logic [21:0] sleepPollHold_reg;
	logic        sleepMode_reg;
	logic [21:0] debMask;
	logic [21:0] statusMasked;
	logic [21:0] readData;
	logic [6:0]  rxAddr;
	logic        rxWrite;
	logic [23:0] rxData;
	logic        fastChange;
	logic        slowChange;
	logic        extendDone;
	logic        wakeNow;
	logic        sleepEntry;

	spi_frame_engine u_engine (
		.clk  (clk),
		.srst (srst),
		.csN  (csN),
		.sclk (sclk),
		.mosi (mosi),
		.link (link.engine)
	);

	// ****************************************************************
	// Frame fields
	// ****************************************************************
	assign rxAddr  = link.rxWord[switch_cfg_pkg::ADDR_MSB:switch_cfg_pkg::ADDR_LSB];
	assign rxWrite = link.rxWord[switch_cfg_pkg::DIR_BIT];
	assign rxData  = link.rxWord[23:0];

	// Status bit order: ground inputs in 13..0, programmable inputs in 21..14.
	assign debMask = {debProg_reg, debGround_reg};

	// ****************************************************************
	// Switch pin synchronisers and normal-mode change detection
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			swMeta_reg <= 22'h000000;
			swSync_reg <= 22'h000000;
			swPrev_reg <= 22'h000000;
		end else begin
			swMeta_reg <= switchPins;
			swSync_reg <= swMeta_reg;
			swPrev_reg <= swSync_reg;
		end
	end

	// ****************************************************************
	// Configuration registers; only reset and whole write frames touch them.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			debProg_reg   <= switch_cfg_pkg::WAKE_DEB_PROG_RESET;
			debGround_reg <= switch_cfg_pkg::WAKE_DEB_GROUND_RESET;
			analogSel_reg <= switch_cfg_pkg::ANALOG_SEL_RESET;
			analogCur_reg <= switch_cfg_pkg::ANALOG_CUR_RESET;
		end else if (link.frameDone && rxWrite) begin
			if (rxAddr == switch_cfg_pkg::ADDR_WAKE_DEB_PROG) begin
				debProg_reg <= rxData[7:0];
			end else if (rxAddr == switch_cfg_pkg::ADDR_WAKE_DEB_GROUND) begin
				debGround_reg <= rxData[13:0];
			end else if (rxAddr == switch_cfg_pkg::ADDR_ANALOG_MUX) begin
				analogSel_reg <= rxData[switch_cfg_pkg::SEL_MSB:switch_cfg_pkg::SEL_LSB];
				analogCur_reg <= rxData[switch_cfg_pkg::CURRENT_BIT];
			end
		end
	end

	// ****************************************************************
	// Address of the last whole frame selects the next response.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			prevAddr_reg <= switch_cfg_pkg::ADDR_SWITCH_STATUS;
		end else if (link.frameDone) begin
			prevAddr_reg <= rxAddr;
		end
	end

	// Codes 1 to 22 name status bit code minus one; others touch none.
	always_comb begin
		for (int i = 0; i < switch_cfg_pkg::CHANNELS; i++) begin
			statusMasked[i] = swSync_reg[i] && (analogSel_reg != 6'(i + 1));
		end
	end

	always_comb begin
		if (prevAddr_reg == switch_cfg_pkg::ADDR_WAKE_DEB_PROG) begin
			readData = {14'h0000, debProg_reg};
		end else if (prevAddr_reg == switch_cfg_pkg::ADDR_WAKE_DEB_GROUND) begin
			readData = {8'h00, debGround_reg};
		end else if (prevAddr_reg == switch_cfg_pkg::ADDR_ANALOG_MUX) begin
			readData = {15'h0000, analogCur_reg, analogSel_reg};
		end else if (prevAddr_reg == switch_cfg_pkg::ADDR_SWITCH_STATUS) begin
			readData = statusMasked;
		end else begin
			// The sleep command is write-only and answers with zero data.
			readData = 22'h000000;
		end
	end

	always_comb begin
		if (wakeReport_reg) begin
			txWord_next = {switch_cfg_pkg::RESPONSE_UPPER, 1'b1, 1'b1, statusMasked};
		end else begin
			txWord_next = {switch_cfg_pkg::RESPONSE_UPPER, faultFlag_reg, changeFlag_reg,
				readData};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			txWord_reg <= 32'h00000000;
		end else begin
			txWord_reg <= txWord_next;
		end
	end

	assign link.txWord = txWord_reg;

	// ****************************************************************
	// Fault and change flags; a set in the clearing cycle wins.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			faultFlag_reg <= 1'b1;
		end else if (faultEvent) begin
			faultFlag_reg <= 1'b1;
		end else if (link.frameDone && !rxWrite
				&& (rxAddr == switch_cfg_pkg::ADDR_FAULT_STATUS)) begin
			faultFlag_reg <= 1'b0;
		end
	end

	// The flag is only cleared when the response register carries it in the cycle after the load.
	always_ff @(posedge clk) begin
		if (srst) begin
			changeFlag_reg <= 1'b1;
		end else if (faultEvent || ((swSync_reg != swPrev_reg)
				&& (state_reg == switch_cfg_pkg::ST_NORMAL))) begin
			changeFlag_reg <= 1'b1;
		end else if (link.frameStart && txWord_reg[switch_cfg_pkg::CHANGE_BIT]) begin
			changeFlag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wakeReport_reg <= 1'b0;
		end else if (wakeNow) begin
			wakeReport_reg <= 1'b1;
		end else if (link.frameStart) begin
			wakeReport_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// Sleep polling state machine
	// ****************************************************************
	assign sleepEntry = link.frameDone && rxWrite
		&& (rxAddr == switch_cfg_pkg::ADDR_ENTER_SLEEP)
		&& (rxData == switch_cfg_pkg::ENTER_SLEEP_DATA)
		&& (state_reg == switch_cfg_pkg::ST_NORMAL);

	assign fastChange = |(diffChange & ~debMask);
	assign extendDone = extendCount_reg == CW'(EXTEND_CYCLES - 1);
	assign slowChange = |((finalLevel ^ lastStatus_reg) & debMask);

	always_comb begin
		state_next = state_reg;
		wakeNow    = 1'b0;
		case (state_reg)
			switch_cfg_pkg::ST_NORMAL: begin
				if (sleepEntry) begin
					state_next = switch_cfg_pkg::ST_SLEEP;
				end
			end
			switch_cfg_pkg::ST_SLEEP: begin
				if (link.frameStart || wakeRequest || (pollStart && fastChange)) begin
					wakeNow    = 1'b1;
					state_next = switch_cfg_pkg::ST_NORMAL;
				end else if (pollStart && (|debMask)) begin
					state_next = switch_cfg_pkg::ST_EXTEND;
				end
			end
			switch_cfg_pkg::ST_EXTEND: begin
				if (link.frameStart || wakeRequest || (extendDone && slowChange)) begin
					wakeNow    = 1'b1;
					state_next = switch_cfg_pkg::ST_NORMAL;
				end else if (extendDone) begin
					state_next = switch_cfg_pkg::ST_SLEEP;
				end
			end
			default: begin
				state_next = switch_cfg_pkg::ST_NORMAL;
			end
		endcase
	end

	// Waking changes state and sets the wake report flag; configuration registers are left as they are.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= switch_cfg_pkg::ST_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// Reference levels for debounced channels are the states seen at entry.
	always_ff @(posedge clk) begin
		if (srst) begin
			lastStatus_reg <= 22'h000000;
		end else if (sleepEntry) begin
			lastStatus_reg <= swSync_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			extendCount_reg <= '0;
		end else if (state_reg == switch_cfg_pkg::ST_EXTEND) begin
			extendCount_reg <= extendCount_reg + CW'(1);
		end else begin
			extendCount_reg <= '0;
		end
	end

	// Polling current is held on only the debounced channels while extending.
	always_ff @(posedge clk) begin
		if (srst) begin
			sleepPollHold_reg <= 22'h000000;
			sleepMode_reg     <= 1'b0;
		end else begin
			sleepPollHold_reg <= (state_next == switch_cfg_pkg::ST_EXTEND) ?
				debMask : 22'h000000;
			sleepMode_reg     <= state_next != switch_cfg_pkg::ST_NORMAL;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign miso                   = link.misoBit;
	assign misoOe                 = link.misoOe;
	assign sleepMode              = sleepMode_reg;
	assign sleepPollHold          = sleepPollHold_reg;
	assign analogChannelSel       = analogSel_reg;
	assign analogSourceCurrentSel = analogCur_reg;

endmodule : switch_cfg_regs

`default_nettype wire

// ===== shared/switch_cfg_pkg.sv
// Overview of operation
// - Debounce bit clear: sleep polling decides change by voltage-difference comparison.
// - Debounce bit set: hold polling current 1.2 ms more, judge final voltage.
// - Register 0x1a holds eight programmable-input debounce enables, bits 7..0, reset zero.
// - Register 0x1b holds fourteen ground-switch debounce enables, bits 13..0, reset zero.
// - Sleep polling mode is entered only by the dedicated entry command.
// - Leaving sleep polling mode keeps every register setting unchanged.
// - Entry command: address 0x1c, write bit set, data zero; write-only.
// - First response after waking reports both flags high plus current pin states.
// - Register 0x1d: channel select bits 5..0, source-current select bit 6, bit 7 unused.
// - Analog channel select resets to no input routed.
// - The input chosen as analog channel reads as 0 in following status responses.
// - Source-current select 0 leaves input high-impedance, 1 applies contact current.
// - Analog channel select updates are accepted at any time in normal mode.
// - Response: fault flag bit 23, change flag bit 22, register data bits 21..0.
// - Select codes: 0 none, 1-14 ground, 15-22 programmable, 23 temperature, 24 battery.
// - Change flag sets on input change or fault, clears once returned.
// - Fault flag sets on any fault, clears only after fault register read.
`default_nettype none

package switch_cfg_pkg;

	// ****************************************************************
	// Frame layout
	// ****************************************************************
	localparam int FRAME_BITS   = 32;
	localparam int ADDR_MSB     = 31;
	localparam int ADDR_LSB     = 25;
	localparam int DIR_BIT      = 24;
	localparam int FAULT_BIT    = 23;
	localparam int CHANGE_BIT   = 22;
	localparam int CHANNELS     = 22;
	localparam int PROG_INPUTS  = 8;
	localparam int GROUND_INPUTS = 14;

	// ****************************************************************
	// Register addresses
	// ****************************************************************
	localparam logic [6:0] ADDR_WAKE_DEB_PROG   = 7'h1a;
	localparam logic [6:0] ADDR_WAKE_DEB_GROUND = 7'h1b;
	localparam logic [6:0] ADDR_ENTER_SLEEP     = 7'h1c;
	localparam logic [6:0] ADDR_ANALOG_MUX      = 7'h1d;
	localparam logic [6:0] ADDR_SWITCH_STATUS   = 7'h1f;
	localparam logic [6:0] ADDR_FAULT_STATUS    = 7'h21;

	// ****************************************************************
	// Fields and reset values
	// ****************************************************************
	localparam int SEL_LSB     = 0;
	localparam int SEL_MSB     = 5;
	localparam int CURRENT_BIT = 6;
	localparam logic [7:0]  WAKE_DEB_PROG_RESET   = 8'h00;
	localparam logic [13:0] WAKE_DEB_GROUND_RESET = 14'h0000;
	localparam logic [5:0]  ANALOG_SEL_RESET      = 6'h00;
	localparam logic        ANALOG_CUR_RESET      = 1'b0;
	localparam logic [23:0] ENTER_SLEEP_DATA      = 24'h000000;
	localparam logic [7:0]  RESPONSE_UPPER        = 8'h00;
	localparam logic [5:0]  SEL_NONE              = 6'h00;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ          = 50;
	localparam int EXTEND_TIME_US   = 1200;
	localparam int EXTEND_CYCLES    = EXTEND_TIME_US * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_NORMAL = 3'b001,
		ST_SLEEP  = 3'b010,
		ST_EXTEND = 3'b100
	} power_state_t;

endpackage : switch_cfg_pkg

`default_nettype wire

// ===== shared/spi_frame_if.sv
`timescale 1ns/10ps
`default_nettype none

interface spi_frame_if;
	logic        frameStart;
	logic        frameDone;
	logic [31:0] rxWord;
	logic [31:0] txWord;
	logic        misoBit;
	logic        misoOe;

	modport engine (
		output frameStart,
		output frameDone,
		output rxWord,
		output misoBit,
		output misoOe,
		input  txWord
	);

	modport core (
		input  frameStart,
		input  frameDone,
		input  rxWord,
		input  misoBit,
		input  misoOe,
		output txWord
	);
endinterface : spi_frame_if

`default_nettype wire

// ===== rtl/spi_frame_engine.sv
`timescale 1ns/10ps
`default_nettype none

module spi_frame_engine (
	input  wire logic   clk,
	input  wire logic   srst,
	input  wire logic   csN,
	input  wire logic   sclk,
	input  wire logic   mosi,
	spi_frame_if.engine link
);

	logic [2:0] csPipe_reg;
	logic [2:0] sclkPipe_reg;
	logic [1:0] mosiPipe_reg;
	logic [5:0] bitCount_reg;
	logic [31:0] rxShift_reg;
	logic [31:0] txShift_reg;
	logic        frameStart_reg;
	logic        frameDone_reg;
	logic [31:0] rxWord_reg;
	logic        misoBit_reg;
	logic        misoOe_reg;
	logic        csFall;
	logic        csRise;
	logic        sclkRise;
	logic        sclkFall;

	// ****************************************************************
	// Pin synchronisers; bit 0 is the first stage, read only by bit 1.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			csPipe_reg   <= 3'h7;
			sclkPipe_reg <= 3'h0;
			mosiPipe_reg <= 2'h0;
		end else begin
			csPipe_reg   <= {csPipe_reg[1:0], csN};
			sclkPipe_reg <= {sclkPipe_reg[1:0], sclk};
			mosiPipe_reg <= {mosiPipe_reg[0], mosi};
		end
	end

	assign csFall   = csPipe_reg[2] & ~csPipe_reg[1];
	assign csRise   = ~csPipe_reg[2] & csPipe_reg[1];
	assign sclkRise = ~csPipe_reg[1] & ~sclkPipe_reg[2] & sclkPipe_reg[1];
	assign sclkFall = ~csPipe_reg[1] & sclkPipe_reg[2] & ~sclkPipe_reg[1];

	// ****************************************************************
	// Receive: sample on rising clock, accept only whole frames.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			bitCount_reg   <= 6'h00;
			rxShift_reg    <= 32'h00000000;
			rxWord_reg     <= 32'h00000000;
			frameDone_reg  <= 1'b0;
			frameStart_reg <= 1'b0;
		end else begin
			frameStart_reg <= csFall;
			frameDone_reg  <= csRise && (bitCount_reg == 6'(switch_cfg_pkg::FRAME_BITS));
			if (csRise && (bitCount_reg == 6'(switch_cfg_pkg::FRAME_BITS))) begin
				rxWord_reg <= rxShift_reg;
			end
			if (csFall) begin
				bitCount_reg <= 6'h00;
			end else if (sclkRise && (bitCount_reg != 6'h3f)) begin
				rxShift_reg  <= {rxShift_reg[30:0], mosiPipe_reg[1]};
				bitCount_reg <= bitCount_reg + 6'h01;
			end
		end
	end

	// ****************************************************************
	// Transmit: most significant bit at select, next bit on falling clock.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			txShift_reg <= 32'h00000000;
			misoBit_reg <= 1'b0;
			misoOe_reg  <= 1'b0;
		end else begin
			misoOe_reg <= ~csPipe_reg[1];
			if (csFall) begin
				misoBit_reg <= link.txWord[31];
				txShift_reg <= {link.txWord[30:0], 1'b0};
			end else if (sclkFall) begin
				misoBit_reg <= txShift_reg[31];
				txShift_reg <= {txShift_reg[30:0], 1'b0};
			end
		end
	end

	assign link.frameStart = frameStart_reg;
	assign link.frameDone  = frameDone_reg;
	assign link.rxWord     = rxWord_reg;
	assign link.misoBit    = misoBit_reg;
	assign link.misoOe     = misoOe_reg;

endmodule : spi_frame_engine

`default_nettype wire

// ===== bench/switch_cfg_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module switch_cfg_regs_asserts #(
	parameter int EXTEND_CYCLES = 20
) (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        csN,
	input wire logic        misoOe,
	input wire logic        wakeRequest,
	input wire logic        pollStart,
	input wire logic        sleepMode,
	input wire logic [21:0] sleepPollHold,
	input wire logic [5:0]  analogChannelSel,
	input wire logic        analogSourceCurrentSel
);
	// ****************************************************************
	// Port checks
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	int holdCnt_reg;

	// Counts the cycles of the running debounce extension.
	always_ff @(posedge clk) begin
		if (srst || !(|sleepPollHold)) begin
			holdCnt_reg <= 0;
		end else begin
			holdCnt_reg <= holdCnt_reg + 1;
		end
	end

	oe_on_a: assert property ($fell(csN) |-> ##[2:5] misoOe)
		else $error("data out not enabled after select");
	oe_off_a: assert property (csN [*6] |-> !misoOe)
		else $error("data out enabled while deselected");
	sel_update_a: assert property ($changed(analogChannelSel) |-> csN && $past(csN, 3))
		else $error("analog select changed outside frame end");
	cur_update_a: assert property ($changed(analogSourceCurrentSel) |-> csN && $past(csN, 3))
		else $error("source current select changed outside frame end");
	sleep_entry_a: assert property ($rose(sleepMode) |-> csN && $past(csN, 2))
		else $error("sleep entered without a finished frame");
	hold_sleep_a: assert property ((|sleepPollHold) |-> sleepMode)
		else $error("polling hold outside sleep");
	hold_bound_a: assert property (holdCnt_reg <= EXTEND_CYCLES)
		else $error("debounce extension too long");
	hold_start_a: assert property ($rose(|sleepPollHold) |->
		$past(pollStart) || $past(pollStart, 2) || $past(pollStart, 3))
		else $error("extension started without a poll");
	wake_req_a: assert property (sleepMode && wakeRequest |-> ##[1:4] !sleepMode)
		else $error("wake request ignored");
	sleep_stay_a: assert property ((sleepMode && csN && !wakeRequest && !pollStart
		&& !(|sleepPollHold)) [*4] |=> sleepMode)
		else $error("left sleep without a cause");
endmodule : switch_cfg_regs_asserts

bind switch_cfg_regs switch_cfg_regs_asserts #(.EXTEND_CYCLES(EXTEND_CYCLES)) chk (
	.clk(clk), .srst(srst), .csN(csN), .misoOe(misoOe), .wakeRequest(wakeRequest),
	.pollStart(pollStart), .sleepMode(sleepMode), .sleepPollHold(sleepPollHold),
	.analogChannelSel(analogChannelSel), .analogSourceCurrentSel(analogSourceCurrentSel)
);

`default_nettype wire

// ===== bench/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
	output logic     csN,
	output logic     sclk,
	output logic     mosi,
	input wire logic miso
);
	// ****************************************************************
	// Serial host
	// ****************************************************************
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	// One frame, MSB first; stretch s slows every phase, the clock stands low between frames.
	task automatic xfer(input logic [31:0] w, input int n, input int s, output logic [31:0] r);
		int i;
		r = '0;
		csN = 1'b0;
		#(160 * s);
		for (i = 0; i < n; i++) begin
			mosi = w[31 - i];
			#(80 * s) sclk = 1'b1;
			#(80 * s - 4) r = {r[30:0], miso};
			#4 sclk = 1'b0;
		end
		#(80 * s) csN = 1'b1;
		mosi = ~mosi;
		#(120 * s);
	endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// ===== bench/tb_lpm_debounce_analog_output_mux_config.sv
`timescale 1ns/10ps
`default_nettype none

module tb_lpm_debounce_analog_output_mux_config;
	// ****************************************************************
	// Bench
	// ****************************************************************
	localparam int EXT = 20;
	logic        clk, srst, csN, sclk, mosi, miso, misoOe, faultEvent, wakeRequest, pollStart;
	logic [21:0] switchPins, diffChange, finalLevel, sleepPollHold;
	logic        sleepMode, analogSourceCurrentSel, fFlag, cFlag, wakeNext, prevValid, w;
	logic [5:0]  analogChannelSel;
	logic [7:0]  prog;
	logic [13:0] gnd;
	logic [6:0]  analog_output_mux, prevAddr, a;
	logic [6:0]  tbl [7];
	logic [23:0] d;
	int          fail_count, checks_done, seed, holdCycles, i;

	switch_cfg_regs #(.EXTEND_CYCLES(EXT)) DUT (
		.clk(clk), .srst(srst), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso),
		.misoOe(misoOe), .switchPins(switchPins), .faultEvent(faultEvent),
		.wakeRequest(wakeRequest), .pollStart(pollStart), .diffChange(diffChange),
		.finalLevel(finalLevel), .sleepMode(sleepMode), .sleepPollHold(sleepPollHold),
		.analogChannelSel(analogChannelSel), .analogSourceCurrentSel(analogSourceCurrentSel)
	);
	spi_host_model host (.csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : checkWord

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick

	function automatic logic [21:0] statusWord();
		logic [21:0] m;
		m = (analog_output_mux[5:0] >= 6'h01 && analog_output_mux[5:0] <= 6'h16) ? 22'h000001 << (analog_output_mux[5:0] - 6'h01) : '0;
		return switchPins & ~m;
	endfunction : statusWord

	function automatic logic [21:0] regData(input logic [6:0] ad);
		case (ad)
			switch_cfg_pkg::ADDR_WAKE_DEB_PROG: return {14'h0000, prog};
			switch_cfg_pkg::ADDR_WAKE_DEB_GROUND: return {8'h00, gnd};
			switch_cfg_pkg::ADDR_ANALOG_MUX: return {15'h0000, analog_output_mux};
			switch_cfg_pkg::ADDR_SWITCH_STATUS: return statusWord();
			default: return 22'h000000;
		endcase
	endfunction : regData

	// A short frame only shifts in the top n bits of the response, right-aligned.
	task automatic frame(input logic [6:0] ad, input logic wr, input logic [23:0] dt, input int n);
		logic [31:0] r;
		logic [31:0] e;
		host.xfer({ad, wr, dt}, n, 1 + ($random(seed) & 1), r);
		if (wakeNext) begin
			checkWord(r, {8'h00, 2'b11, statusWord()} >> (32 - n));
		end else if (prevValid && prevAddr != switch_cfg_pkg::ADDR_FAULT_STATUS) begin
			e = {8'h00, fFlag, cFlag, regData(prevAddr)};
			checkWord(r, e >> (32 - n));
		end
		cFlag = 1'b0;
		wakeNext = 1'b0;
		if (n == 32 && wr) begin
			case (ad)
				switch_cfg_pkg::ADDR_WAKE_DEB_PROG: prog = dt[7:0];
				switch_cfg_pkg::ADDR_WAKE_DEB_GROUND: gnd = dt[13:0];
				switch_cfg_pkg::ADDR_ANALOG_MUX: analog_output_mux = dt[6:0];
				default: ;
			endcase
		end
		if (n == 32 && !wr && ad == switch_cfg_pkg::ADDR_FAULT_STATUS) fFlag = 1'b0;
		if (n == 32 && wr && ad == switch_cfg_pkg::ADDR_ANALOG_MUX)
			checkWord({analogSourceCurrentSel, analogChannelSel}, {25'h0, analog_output_mux});
		prevAddr = ad;
		prevValid = (n == 32);
	endtask : frame

	task automatic enterSleep();
		frame(switch_cfg_pkg::ADDR_ENTER_SLEEP, 1'b1, switch_cfg_pkg::ENTER_SLEEP_DATA, 32);
		checkWord({31'h0, sleepMode}, 32'h1);
	endtask : enterSleep

	task automatic poll(input logic [21:0] dc, input logic [21:0] fl, input int eh, input logic es);
		diffChange = dc;
		finalLevel = fl;
		pollStart = 1'b1;
		holdCycles = 0;
		repeat (EXT + 10) begin
			tick(1);
			pollStart = 1'b0;
			if (|sleepPollHold) begin
				holdCycles++;
				checkWord({10'h0, sleepPollHold}, {10'h0, prog, gnd});
			end
		end
		checkWord(holdCycles, eh);
		checkWord({31'h0, sleepMode}, {31'h0, es});
		wakeNext = !es;
	endtask : poll

	task automatic tally_and_finish();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#1200000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		seed = 32'h6bf2a3a0;
		fail_count = 0;
		checks_done = 0;
		{srst, faultEvent, wakeRequest, pollStart} = 4'h8;
		{diffChange, finalLevel, prog, gnd, analog_output_mux} = '0;
		switchPins = 22'($random(seed));
		tbl = '{switch_cfg_pkg::ADDR_WAKE_DEB_PROG, switch_cfg_pkg::ADDR_WAKE_DEB_GROUND,
			switch_cfg_pkg::ADDR_ANALOG_MUX, switch_cfg_pkg::ADDR_ENTER_SLEEP, 7'h05,
			switch_cfg_pkg::ADDR_FAULT_STATUS, switch_cfg_pkg::ADDR_SWITCH_STATUS};
		prevAddr = switch_cfg_pkg::ADDR_SWITCH_STATUS;
		{prevValid, fFlag, cFlag, wakeNext} = 4'he;
		tick(6);
		srst = 1'b0;
		tick(3);
		checkWord({sleepPollHold, analogChannelSel, analogSourceCurrentSel, sleepMode}, 0);
		for (i = 0; i < 7; i++) frame(tbl[i], 1'b0, 24'h000000, 32);
		for (i = 0; i < 48; i++) begin
			if (i % 8 == 3) begin
				switchPins = 22'($random(seed));
				tick(10);
				cFlag = 1'b1;
			end
			if (i % 8 == 6) begin
				faultEvent = 1'b1;
				tick(1);
				faultEvent = 1'b0;
				tick(4);
				{fFlag, cFlag} = 2'b11;
			end
			a = tbl[($random(seed) & 32'h7fffffff) % 7];
			w = 1'($random(seed));
			d = 24'($random(seed));
			d[5:0] = 6'(($random(seed) & 32'h7fffffff) % 25);
			if (a == switch_cfg_pkg::ADDR_ENTER_SLEEP) d[23] = 1'b1;
			frame(a, w, d, 32);
			checkWord({31'h0, sleepMode}, 32'h0);
			if (i == 20) frame(switch_cfg_pkg::ADDR_ANALOG_MUX, 1'b1, 24'h000055, 31);
		end
		frame(switch_cfg_pkg::ADDR_ANALOG_MUX, 1'b1, 24'h000000, 32);
		frame(switch_cfg_pkg::ADDR_WAKE_DEB_PROG, 1'b1, 24'hffff80, 32);
		frame(switch_cfg_pkg::ADDR_WAKE_DEB_GROUND, 1'b1, 24'hff0001, 32);
		enterSleep();
		poll(22'h000001, switchPins, EXT, 1'b1);
		poll(22'h000002, switchPins, 0, 1'b0);
		frame(switch_cfg_pkg::ADDR_WAKE_DEB_PROG, 1'b0, 24'h000000, 32);
		frame(switch_cfg_pkg::ADDR_WAKE_DEB_GROUND, 1'b0, 24'h000000, 32);
		enterSleep();
		poll(22'h000000, switchPins ^ 22'h200000, EXT, 1'b0);
		frame(switch_cfg_pkg::ADDR_ANALOG_MUX, 1'b0, 24'h000000, 32);
		enterSleep();
		wakeRequest = 1'b1;
		tick(1);
		wakeRequest = 1'b0;
		tick(4);
		checkWord({31'h0, sleepMode}, 32'h0);
		wakeNext = 1'b1;
		frame(switch_cfg_pkg::ADDR_SWITCH_STATUS, 1'b0, 24'h000000, 32);
		frame(switch_cfg_pkg::ADDR_WAKE_DEB_GROUND, 1'b0, 24'h000000, 32);
		frame(switch_cfg_pkg::ADDR_WAKE_DEB_PROG, 1'b0, 24'h000000, 32);
		tally_and_finish();
	end
endmodule : tb_lpm_debounce_analog_output_mux_config

`default_nettype wire
